// ### hdl/rtcpw_pkg.sv
package rtcpw_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_WDHR      = 8'h00;
    localparam logic [7:0]  ADDR_MINSEC    = 8'h04;
    localparam logic [7:0]  ADDR_WINDOW    = 8'h08;
    localparam logic [7:0]  ADDR_CTRL      = 8'h0C;
    localparam logic [7:0]  ADDR_CLOCK     = 8'h10;
    localparam logic [7:0]  ADDR_STATUS    = 8'h14;
    localparam logic [7:0]  ADDR_MASK      = 8'h18;

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam logic [15:0] WDHR_MASK      = 16'h073F;
    localparam logic [15:0] MINSEC_MASK    = 16'h7F7F;
    localparam int          DAY_LSB        = 8;
    localparam int          STAB_LSB       = 8;
    localparam int          CTRL_UNLOCK    = 0;
    localparam int          CTRL_PWR_EN    = 1;
    localparam int          CTRL_CLKEN     = 2;
    localparam int          CTRL_PINPWC    = 3;
    localparam int          CTRL_MSB       = 7;
    localparam int          MMASK_LSB      = 4;
    localparam logic [7:0]  SAMP_ALWAYS    = 8'hFF;
    localparam logic [2:0]  DAY_MAX        = 3'h6;

    // status bits: alarm event, sample window closed
    localparam int          ST_ALARM       = 0;
    localparam int          ST_DONE        = 1;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_ZERO16     = 16'h0000;
    localparam logic [7:0]  RST_ZERO8      = 8'h00;
    localparam logic [1:0]  RST_ZERO2      = 2'h0;

    typedef enum logic [1:0] {PW_IDLE, PW_STAB, PW_SAMP} rtcpw_state_t;

endpackage

// ### hdl/rtcpw_top.sv
`timescale 1ns/1ns
module rtcpw_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wake_pin,
    output logic             power_ctrl_out,
    output logic             sample_open,
    output logic             wake_seen,
    output logic             irq
);
    import rtcpw_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0]  wdhr;
        logic [15:0]  minsec;
        logic [15:0]  window;
        logic [7:0]   ctrl;
        logic [18:0]  clock;
        logic [1:0]   status;
        logic [1:0]   mask;
        rtcpw_state_t st;
        logic [7:0]   cnt;
        logic         wake_s1;
        logic         wake_s2;
        logic         wake;
        logic [31:0]  rdata;
    } rtcpw_regs_t;

    rtcpw_regs_t s_r;
    rtcpw_regs_t s_nxt;

    logic        wr;
    logic        rd;
    logic        alarm_event;
    logic        pwc_run;
    logic [3:0]  mmask;
    logic [7:0]  stab_len;
    logic [7:0]  samp_len;
    logic        samp_always;
    logic        dig_s;
    logic        dig_m;
    logic        dig_h;
    logic        dig_d;
    logic        mapped;

    // ----------------------------------------------------------------
    // decode and match
    // ----------------------------------------------------------------
    // zero wait states: the access phase always completes at once
    assign pready   = 1'b1;
    assign mapped   = (paddr <= ADDR_MASK) && (paddr[1:0] == 2'b00);
    assign pslverr  = psel && penable && !mapped;
    assign wr       = psel && penable && pwrite && mapped;
    assign rd       = psel && !penable && !pwrite;
    assign stab_len = s_r.window[15:STAB_LSB];
    assign samp_len = s_r.window[7:0];
    assign samp_always = (samp_len == SAMP_ALWAYS);
    assign mmask    = s_r.ctrl[CTRL_MSB:MMASK_LSB];
    // digits of the value being written, so the alarm fires as the clock reaches it
    assign dig_s    = pwdata[6:0] == s_r.minsec[6:0];
    assign dig_m    = pwdata[14:8] == s_r.minsec[14:8];
    assign dig_h    = pwdata[5:0] == s_r.wdhr[5:0];
    assign dig_d    = pwdata[18:16] == s_r.wdhr[10:DAY_LSB];
    // mask 0: every clock update while CTRL_CLKEN is set; 1..3 add seconds, minutes, hours; 4+ adds weekday
    assign alarm_event = s_r.ctrl[CTRL_CLKEN] && (wr && paddr == ADDR_CLOCK) &&
                         ((mmask < 4'h1) || dig_s) && ((mmask < 4'h2) || dig_m) &&
                         ((mmask < 4'h3) || dig_h) && ((mmask < 4'h4) || dig_d);
    assign pwc_run  = s_r.ctrl[CTRL_CLKEN] && s_r.ctrl[CTRL_PWR_EN] &&
                      s_r.ctrl[CTRL_PINPWC];

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.wake_s1 = wake_pin;
        s_nxt.wake_s2 = s_r.wake_s1;
        s_nxt.wake = 1'b0;
        // register writes
        if (wr) begin
            unique case (paddr)
                ADDR_WDHR: begin
                    if (s_r.ctrl[CTRL_UNLOCK] &&
                        pwdata[10:DAY_LSB] <= DAY_MAX) begin
                        s_nxt.wdhr = pwdata[15:0] & WDHR_MASK;
                    end
                end
                ADDR_MINSEC: s_nxt.minsec = pwdata[15:0] & MINSEC_MASK;
                ADDR_WINDOW: begin
                    if (s_r.ctrl[CTRL_UNLOCK]) begin
                        s_nxt.window = pwdata[15:0];
                    end
                end
                ADDR_CTRL:   s_nxt.ctrl = pwdata[7:0];
                ADDR_CLOCK:  s_nxt.clock = pwdata[18:0];
                ADDR_MASK:   s_nxt.mask = pwdata[1:0];
                default: begin
                end
            endcase
        end
        // window sequencer
        unique case (s_r.st)
            PW_IDLE: begin
            end
            PW_STAB: begin
                if (s_r.cnt <= 8'h01) begin
                    s_nxt.st  = PW_SAMP;
                    s_nxt.cnt = samp_len;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            PW_SAMP: begin
                if (s_r.cnt <= 8'h01) begin
                    s_nxt.st = PW_IDLE;
                    s_nxt.status[ST_DONE] = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
        endcase
        if (!pwc_run && s_r.st != PW_IDLE) begin
            s_nxt.st = PW_IDLE;
        end
        // an alarm restarts the sequence from the top
        if (alarm_event && pwc_run) begin
            if (stab_len == RST_ZERO8) begin
                s_nxt.st  = PW_SAMP;
                s_nxt.cnt = samp_len;
            end else begin
                s_nxt.st  = PW_STAB;
                s_nxt.cnt = stab_len;
            end
        end
        // zero-length sample window collapses straight back to idle
        if (s_nxt.st == PW_SAMP && s_nxt.cnt == RST_ZERO8 && !samp_always) begin
            s_nxt.st = PW_IDLE;
        end
        // sample wake-ups only while open
        if (sample_open && s_r.wake_s2) begin
            s_nxt.wake = 1'b1;
        end
        // status: write-one-to-clear, hardware set wins
        if (wr && paddr == ADDR_STATUS) begin
            s_nxt.status = s_r.status & ~pwdata[1:0];
        end
        if (alarm_event) begin
            s_nxt.status[ST_ALARM] = 1'b1;
        end
        if (s_r.st == PW_SAMP && s_nxt.st == PW_IDLE && pwc_run) begin
            s_nxt.status[ST_DONE] = 1'b1;
        end
        // read data captured in setup phase
        s_nxt.rdata = 32'h0000_0000;
        if (rd) begin
            unique case (paddr)
                ADDR_WDHR:   s_nxt.rdata = {16'h0000, s_r.wdhr & WDHR_MASK};
                ADDR_MINSEC: s_nxt.rdata = {16'h0000, s_r.minsec & MINSEC_MASK};
                ADDR_WINDOW: s_nxt.rdata = {16'h0000, s_r.window};
                ADDR_CTRL:   s_nxt.rdata = {24'h00_0000, s_r.ctrl};
                ADDR_CLOCK:  s_nxt.rdata = {13'h0000, s_r.clock};
                ADDR_STATUS: s_nxt.rdata = {24'h00_0000, 2'h0, s_r.st, 2'h0, s_r.status};
                ADDR_MASK:   s_nxt.rdata = {30'h0000_0000, s_r.mask};
                default:     s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign prdata         = s_r.rdata;
    assign sample_open    = samp_always || (s_r.st == PW_SAMP);
    assign power_ctrl_out = pwc_run && (s_r.st != PW_IDLE);
    assign wake_seen      = s_r.wake;
    assign irq            = |(s_r.status & s_r.mask);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_stab_start;
        alarm_event && pwc_run && stab_len != 8'h00;
    endsequence

    property p_locked_wdhr;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_WDHR && !s_r.ctrl[CTRL_UNLOCK]) |=> $stable(s_r.wdhr);
    endproperty
    a_locked_wdhr: assert property (p_locked_wdhr) else $error("locked write landed");

    property p_locked_win;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_WINDOW && !s_r.ctrl[CTRL_UNLOCK]) |=> $stable(s_r.window);
    endproperty
    a_locked_win: assert property (p_locked_win) else $error("window write landed");

    property p_zero_bits;
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == ADDR_WDHR) |=> (prdata[15:11] == 5'h00 && prdata[7:6] == 2'h0);
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("unused bits nonzero");

    property p_stab;
        @(posedge pclk) disable iff (!presetn)
        s_stab_start |=> (s_r.st == PW_STAB && s_r.cnt == $past(stab_len));
    endproperty
    a_stab: assert property (p_stab) else $error("stability not restarted");

    property p_always;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_WINDOW && s_r.ctrl[CTRL_UNLOCK] && pwdata[7:0] == SAMP_ALWAYS)
            |=> sample_open;
    endproperty
    a_always: assert property (p_always) else $error("window not held open");

    property p_direct;
        @(posedge pclk) disable iff (!presetn)
        (alarm_event && pwc_run && stab_len == 8'h00 && samp_len != 8'h00)
            |=> s_r.st == PW_SAMP;
    endproperty
    a_direct: assert property (p_direct) else $error("sample not started");

    property p_handoff;
        @(posedge pclk) disable iff (!presetn)
        (s_r.st == PW_STAB && s_r.cnt == 8'h01 && pwc_run && !alarm_event && samp_len != 8'h00)
            |=> (s_r.st == PW_SAMP && s_r.cnt == $past(samp_len));
    endproperty
    a_handoff: assert property (p_handoff) else $error("no sample after stability");

    property p_run;
        @(posedge pclk) disable iff (!presetn)
        power_ctrl_out |-> (s_r.ctrl[CTRL_CLKEN] && s_r.ctrl[CTRL_PWR_EN] && s_r.ctrl[CTRL_PINPWC]);
    endproperty
    a_run: assert property (p_run) else $error("power control without enable");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        wake_seen |-> $past(sample_open);
    endproperty
    a_wake: assert property (p_wake) else $error("wake outside window");

    // ----------------------------------------------------------------
    // counter and flag checks
    // ----------------------------------------------------------------
    // a tick is a cycle in which the counter only steps down; an alarm may reload it instead
    sequence s_stab_tick;
        s_r.st == PW_STAB && s_r.cnt > 8'h01 && pwc_run && !alarm_event;
    endsequence

    sequence s_samp_tick;
        s_r.st == PW_SAMP && s_r.cnt > 8'h01 && pwc_run && !alarm_event;
    endsequence

    sequence s_samp_last;
        s_r.st == PW_SAMP && s_r.cnt == 8'h01 && pwc_run && !alarm_event;
    endsequence

    property p_stab_count;
        @(posedge pclk) disable iff (!presetn)
        s_stab_tick |=> (s_r.st == PW_STAB && s_r.cnt == $past(s_r.cnt) - 8'h01);
    endproperty
    a_stab_count: assert property (p_stab_count) else $error("stability count slipped");

    property p_samp_count;
        @(posedge pclk) disable iff (!presetn)
        s_samp_tick |=> (s_r.st == PW_SAMP && s_r.cnt == $past(s_r.cnt) - 8'h01);
    endproperty
    a_samp_count: assert property (p_samp_count) else $error("sample count slipped");

    // closing the window is what tells software the external device was sampled
    property p_samp_end;
        @(posedge pclk) disable iff (!presetn)
        s_samp_last |=> (s_r.st == PW_IDLE && s_r.status[ST_DONE]);
    endproperty
    a_samp_end: assert property (p_samp_end) else $error("sample window did not close");

    property p_stop;
        @(posedge pclk) disable iff (!presetn)
        !pwc_run |=> s_r.st == PW_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("sequencer ran while stopped");

    // a clear that lands with a new alarm must not lose the alarm
    property p_alarm_flag;
        @(posedge pclk) disable iff (!presetn)
        alarm_event |=> s_r.status[ST_ALARM];
    endproperty
    a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag lost");

    property p_minsec;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_MINSEC) |=> s_r.minsec == ($past(pwdata[15:0]) & MINSEC_MASK);
    endproperty
    a_minsec: assert property (p_minsec) else $error("min/sec write lost");

    property p_day_range;
        @(posedge pclk) disable iff (!presetn)
        s_r.wdhr[10:DAY_LSB] <= DAY_MAX;
    endproperty
    a_day_range: assert property (p_day_range) else $error("weekday out of range");

    property p_minsec_gaps;
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == ADDR_MINSEC) |=> (prdata[15] == 1'b0 && prdata[7] == 1'b0);
    endproperty
    a_minsec_gaps: assert property (p_minsec_gaps) else $error("gap bits nonzero");

    // the pin crosses two sync stages and the capture flop before it shows
    property p_wake_sync;
        @(posedge pclk) disable iff (!presetn)
        wake_seen |-> $past(wake_pin, 3);
    endproperty
    a_wake_sync: assert property (p_wake_sync) else $error("wake without pin");

    property p_wake_off;
        @(posedge pclk) disable iff (!presetn)
        !sample_open |=> !wake_seen;
    endproperty
    a_wake_off: assert property (p_wake_off) else $error("wake while closed");

endmodule

// ### dv/rtcpw_dev.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// external device switched by the power control output
// ----------------------------------------------------------------
module rtcpw_dev #(
    parameter int WAKE_DLY = 2
) (
    input  wire logic clk,
    input  wire logic pwr,
    output logic      wake
);
    int   up_cnt = 0;
    logic flip   = 1'b0;
    initial wake = 1'b0;
    // unpowered, the wake line floats: toggle it so a held level never passes for data
    always @(posedge clk) begin
        flip   <= ~flip;
        up_cnt <= pwr ? up_cnt + 1 : 0;
        wake   <= pwr ? (up_cnt >= WAKE_DLY) : flip;
    end
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    import rtcpw_pkg::*;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, wake_pin, power_ctrl_out, sample_open, wake_seen, irq;
    logic [31:0] lfsr = 32'hDF5F7CE8;
    logic [31:0] exp_q[$];
    int          error_cnt = 0;
    int          checks    = 0;
    int          n_stab, n_samp, n_wake;

    initial forever #25 pclk = ~pclk;

    rtcpw_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_pin(wake_pin), .power_ctrl_out(power_ctrl_out),
        .sample_open(sample_open), .wake_seen(wake_seen), .irq(irq));
    rtcpw_dev i_dev (.clk(pclk), .pwr(power_ctrl_out), .wake(wake_pin));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic end_of_test();
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one apb transfer; a slave that never answers is left to the watchdog
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        xfer(1'b0, a, 32'h0);
    endtask

    // read data is taken at the completing edge and matched with the oldest note
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            check(prdata, exp_q.pop_front());

    // unmapped or unaligned offsets answer with an error, every other access without
    always @(posedge pclk)
        if (psel && penable && pready)
            check(pslverr, 32'(paddr > ADDR_MASK || paddr[1:0] != 2'b00));

    // fire an alarm, then count stability and sample cycles in a fixed window
    task automatic run_alarm(input logic [7:0] stab, input logic [7:0] samp,
                             input logic [31:0] clk_v, input bit on);
        logic prev_open;
        int   n_late;
        xfer(1'b1, ADDR_WINDOW, {16'h0, stab, samp});
        xfer(1'b1, ADDR_CLOCK, clk_v);
        n_stab = 0;
        n_samp = 0;
        n_wake = 0;
        n_late = 0;
        prev_open = 1'b1;
        repeat (600) begin
            @(negedge pclk);
            if (power_ctrl_out && !sample_open) n_stab++;
            if (sample_open) n_samp++;
            if (sample_open && !power_ctrl_out) n_samp += 1000;
            if (wake_seen) n_wake++;
            if (wake_seen && !prev_open) n_late++;
            prev_open = sample_open;
        end
        check(n_stab, on ? stab : 8'h00);
        check(n_samp, on ? samp : 8'h00);
        check(n_late, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_WDHR, 32'h0);
        rd(ADDR_WINDOW, 32'h0);
        xfer(1'b1, ADDR_WDHR, 32'h0000_0612);
        rd(ADDR_WDHR, 32'h0);
        xfer(1'b1, ADDR_CTRL, 32'h0000_0001);
        xfer(1'b1, ADDR_WDHR, 32'hFFFF_F63F);
        rd(ADDR_WDHR, 32'h0000_063F);
        xfer(1'b1, ADDR_WDHR, 32'h0000_0712);
        rd(ADDR_WDHR, 32'h0000_063F);
        xfer(1'b1, ADDR_MINSEC, 32'hFFFF_FFFF);
        rd(ADDR_MINSEC, 32'h0000_7F7F);
        rd(8'h1C, 32'h0);
        xfer(1'b1, ADDR_WINDOW, 32'h0000_00FF);
        @(negedge pclk);
        check(sample_open, 1'b1);
        // pin not routed: no power cycle
        xfer(1'b1, ADDR_CTRL, 32'h0000_0007);
        run_alarm(8'h02, 8'h03, 32'h0, 0);
        // seconds digit mismatch blocks the alarm, then a seconds and minutes match fires it
        xfer(1'b1, ADDR_CTRL, 32'h0000_001F);
        run_alarm(8'h02, 8'h03, 32'h0, 0);
        xfer(1'b1, ADDR_MINSEC, 32'h0000_0025);
        xfer(1'b1, ADDR_CTRL, 32'h0000_002F);
        xfer(1'b1, ADDR_MASK, 32'h0000_0001);
        xfer(1'b1, ADDR_STATUS, 32'h0000_0003);
        @(negedge pclk);
        check(irq, 1'b0);
        run_alarm(8'h03, 8'h04, 32'h0000_0025, 1);
        // device wakes three cycles after power-up, then two sync stages and the capture flop
        check(n_wake, 32'h2);
        check(irq, 1'b1);
        xfer(1'b1, ADDR_STATUS, 32'h0000_0001);
        @(negedge pclk);
        check(irq, 1'b0);
        xfer(1'b1, ADDR_CTRL, 32'h0000_000F);
        run_alarm(8'h00, 8'h05, 32'h0, 1);
        run_alarm(8'h04, 8'h00, 32'h0, 1);
        repeat (4) run_alarm(8'(rnd() % 8), 8'(rnd() % 20), rnd() & 32'h0007_7F7F, 1);
        end_of_test();
    end

    // hang guard: the sequence needs well under 10000 cycles
    initial begin
        #(20000 * 50);
        error_cnt++;
        end_of_test();
    end
endmodule
